//--- verilog/mrw_host.sv
// Host controller for multi-line flash reads and burst-wrap setting
// Summary of operation
// - Dual read sends address two bits per clock
// - Eight mode bits follow address; upper nibble matters
// - Dual read: host releases lines for the last mode bit pair
// - Lines released before first data clock
// - Dual exit: ones on line zero, sixteen clocks
// - Quad exit: ones on line zero, eight clocks; host always sends sixteen
// - Word read: even address, two dummy clocks
// - Octal read: address low nibble zero, no dummy
// - Wrap command: opcode, 24 ignored, eight bits
// - Wrap off by default; set bit 4 to leave
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "mrw_defines.svh"
module mrw_host (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Flash pins
	output logic             flash_cs_n,
	output logic             flash_sck,
	output logic      [3:0]  data_line_out,
	output logic      [3:0]  data_line_oe,
	input  wire logic [3:0]  data_line_in
);
	mrw_pkg::mrw_reg_s r_r, r_nxt;

	function automatic logic [5:0] addr_clocks(input mrw_pkg::mrw_cmd_e c);
		if (c == mrw_pkg::MRW_C_DUAL)
			addr_clocks = 6'd12;
		else
			addr_clocks = 6'd6;
	endfunction

	function automatic logic [3:0] lane_mask(input mrw_pkg::mrw_cmd_e c);
		lane_mask = (c == mrw_pkg::MRW_C_DUAL) ? 4'h3 : 4'hF;
	endfunction

	logic       apb_wr;
	logic       apb_rd;
	logic       sck_fall;
	logic       sck_rise;
	logic [3:0] lanes;
	logic [2:0] step;

	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;
	assign lanes = lane_mask(r_r.cmd);
	assign step = (r_r.cmd == mrw_pkg::MRW_C_DUAL) ? 3'd2 : 3'd4;

	always_comb begin
		logic [7:0] opc;
		opc = `MRW_OP_DUAL;
		r_nxt = r_r;
		r_nxt.pready = 1'b0;
		r_nxt.sync_a = {r_r.sync_a[0], 1'b0};
		r_nxt.din_a = data_line_in;
		r_nxt.din_b = r_r.din_a;
		sck_rise = 1'b0;
		sck_fall = 1'b0;
		// Divider makes the serial clock; bits change at its low edge
		if (r_r.st != mrw_pkg::MRW_IDLE) begin
			if (r_r.div == 4'(`MRW_DIV_HALF - 1)) begin
				r_nxt.div = 4'h0;
				// Close the frame instead of a spare rising edge
				if (r_r.st == mrw_pkg::MRW_GAP) begin
					r_nxt.pins.cs_n = 1'b1;
					r_nxt.pins.oe = 4'h0;
					r_nxt.st = mrw_pkg::MRW_IDLE;
				end else begin
					r_nxt.pins.sck = !r_r.pins.sck;
					sck_rise = !r_r.pins.sck;
					sck_fall = r_r.pins.sck;
				end
			end else begin
				r_nxt.div = r_r.div + 4'h1;
			end
		end
		if (psel && !penable) begin
			r_nxt.pready = 1'b1;
			unique case (paddr)
			`MRW_OFS_ADDR: r_nxt.prdata = {8'h00, r_r.addr};
			`MRW_OFS_DATA: r_nxt.prdata = {24'h0, r_r.data};
			`MRW_OFS_STAT: r_nxt.prdata = {30'h0, r_r.valid,
					r_r.st != mrw_pkg::MRW_IDLE};
			`MRW_OFS_CTRL: r_nxt.prdata = {8'h00, r_r.wrapb,
					r_r.len, 1'b0, r_r.cmd, 1'b0,
					r_r.skipop, r_r.cont, 1'b0};
			default: r_nxt.prdata = 32'h0;
			endcase
		end
		if (apb_rd && paddr == `MRW_OFS_DATA)
			r_nxt.valid = 1'b0;
		if (apb_wr && paddr == `MRW_OFS_ADDR)
			r_nxt.addr = pwdata[23:0];
		if (apb_wr && paddr == `MRW_OFS_CTRL && r_r.st == mrw_pkg::MRW_IDLE
				&& pwdata[`MRW_CTRL_GO]) begin
			r_nxt.cmd = mrw_pkg::mrw_cmd_e'(pwdata[`MRW_CTRL_CMD_LSB +: 3]);
			r_nxt.cont = pwdata[`MRW_CTRL_CONT];
			r_nxt.len = pwdata[`MRW_CTRL_LEN_LSB +: 8];
			r_nxt.wrapb = pwdata[`MRW_CTRL_WRAP_LSB +: 8];
			r_nxt.nbyte = 8'h0;
			r_nxt.div = 4'h0;
			r_nxt.pins.cs_n = 1'b0;
			r_nxt.pins.oe = 4'h1;
			unique case (mrw_pkg::mrw_cmd_e'(pwdata[`MRW_CTRL_CMD_LSB +: 3]))
			mrw_pkg::MRW_C_QUAD:  opc = `MRW_OP_QUAD;
			mrw_pkg::MRW_C_WORD:  opc = `MRW_OP_WORD;
			mrw_pkg::MRW_C_OCTAL: opc = `MRW_OP_OCTAL;
			mrw_pkg::MRW_C_WRAP:  opc = `MRW_OP_WRAP;
			mrw_pkg::MRW_C_MRST:  opc = `MRW_OP_MODE_RST;
			default:              opc = `MRW_OP_DUAL;
			endcase
			// Skip opcode when the previous read left the mode pair at 10
			if (r_r.skipop && pwdata[`MRW_CTRL_CMD_LSB +: 3] < 3'd4) begin
				r_nxt.st = mrw_pkg::MRW_ADDR;
				r_nxt.cnt = addr_clocks(mrw_pkg::mrw_cmd_e'(
					pwdata[`MRW_CTRL_CMD_LSB +: 3]));
				r_nxt.shreg = {r_r.addr, 8'h00};
				r_nxt.pins.oe = lane_mask(mrw_pkg::mrw_cmd_e'(
					pwdata[`MRW_CTRL_CMD_LSB +: 3]));
			end else begin
				r_nxt.st = mrw_pkg::MRW_OPC;
				r_nxt.shreg = {opc, 24'h0};
				// Mode-reset: all ones on line zero, 16 clocks
				r_nxt.cnt = (pwdata[`MRW_CTRL_CMD_LSB +: 3] == 3'd5) ?
					6'd16 : 6'd8;
				if (pwdata[`MRW_CTRL_CMD_LSB +: 3] == 3'd5)
					r_nxt.shreg = 32'hFFFF_FFFF;
			end
			r_nxt.pins.dout = {3'b000, r_nxt.shreg[31]};
			if (r_nxt.st == mrw_pkg::MRW_ADDR)
				r_nxt.pins.dout = (r_nxt.cmd == mrw_pkg::MRW_C_DUAL) ?
					{2'b00, r_nxt.shreg[31:30]} : r_nxt.shreg[31:28];
			r_nxt.skipop = 1'b0;
		end
		if (sck_rise && r_r.st == mrw_pkg::MRW_DATA) begin
			// Data is sampled at the rising edge, MSB first
			r_nxt.rdbyte = (r_r.cmd == mrw_pkg::MRW_C_DUAL) ?
				{r_r.rdbyte[5:0], r_r.din_b[1:0]} :
				{r_r.rdbyte[3:0], r_r.din_b};
		end
		if (sck_fall) begin
			r_nxt.cnt = r_r.cnt - 6'd1;
			unique case (r_r.st)
			mrw_pkg::MRW_OPC: begin
				r_nxt.shreg = {r_r.shreg[30:0], 1'b1};
				r_nxt.pins.dout = {3'b000, r_r.shreg[30]};
				if (r_r.cnt == 6'd1) begin
					if (r_r.cmd == mrw_pkg::MRW_C_MRST) begin
						r_nxt.st = mrw_pkg::MRW_GAP;
					end else begin
						r_nxt.st = mrw_pkg::MRW_ADDR;
						r_nxt.cnt = (r_r.cmd == mrw_pkg::MRW_C_WRAP) ?
							6'd24 : addr_clocks(r_r.cmd);
						r_nxt.shreg = (r_r.cmd == mrw_pkg::MRW_C_WRAP) ?
							32'h0 : {r_r.addr, 8'h00};
						r_nxt.pins.oe = (r_r.cmd == mrw_pkg::MRW_C_WRAP) ?
							4'h1 : lanes;
						r_nxt.pins.dout = (r_r.cmd == mrw_pkg::MRW_C_WRAP) ?
							4'h0 : r_r.addr[23:20] &
							((r_r.cmd == mrw_pkg::MRW_C_DUAL) ?
							{2'b00, r_r.addr[23:22]} : 4'hF);
						if (r_r.cmd == mrw_pkg::MRW_C_DUAL)
							r_nxt.pins.dout = {2'b00, r_r.addr[23:22]};
					end
				end
			end
			mrw_pkg::MRW_ADDR: begin
				if (r_r.cmd == mrw_pkg::MRW_C_WRAP) begin
					r_nxt.shreg = {r_r.shreg[30:0], 1'b0};
					r_nxt.pins.dout = {3'b000, r_r.cnt == 6'd1 ?
						r_r.wrapb[7] : 1'b0};
					if (r_r.cnt == 6'd1) begin
						r_nxt.st = mrw_pkg::MRW_MODE;
						r_nxt.cnt = 6'd8;
						r_nxt.shreg = {r_r.wrapb, 24'h0};
					end
				end else begin
					r_nxt.shreg = r_r.shreg << step;
					r_nxt.pins.dout = (r_r.cmd == mrw_pkg::MRW_C_DUAL) ?
						{2'b00, r_nxt.shreg[31:30]} : r_nxt.shreg[31:28];
					if (r_r.cnt == 6'd1) begin
						r_nxt.st = mrw_pkg::MRW_MODE;
						r_nxt.cnt = (r_r.cmd == mrw_pkg::MRW_C_DUAL) ?
							6'd4 : 6'd2;
						r_nxt.shreg = {(r_r.cont ? `MRW_MODE_CONT :
							`MRW_MODE_EXIT), 24'h0};
						r_nxt.pins.dout = (r_r.cmd ==
							mrw_pkg::MRW_C_DUAL) ? {2'b00,
							r_nxt.shreg[31:30]} : r_nxt.shreg[31:28];
					end
				end
			end
			mrw_pkg::MRW_MODE: begin
				if (r_r.cmd == mrw_pkg::MRW_C_WRAP) begin
					r_nxt.shreg = {r_r.shreg[30:0], 1'b0};
					r_nxt.pins.dout = {3'b000, r_r.shreg[30]};
					if (r_r.cnt == 6'd1)
						r_nxt.st = mrw_pkg::MRW_GAP;
				end else begin
					r_nxt.shreg = r_r.shreg << step;
					r_nxt.pins.dout = (r_r.cmd == mrw_pkg::MRW_C_DUAL) ?
						{2'b00, r_nxt.shreg[31:30]} : r_nxt.shreg[31:28];
					// Last mode bit pair undriven to widen turnaround
					if (r_r.cnt <= 6'd2 && r_r.cmd == mrw_pkg::MRW_C_DUAL)
						r_nxt.pins.oe = 4'h0;
					if (r_r.cnt == 6'd1) begin
						r_nxt.pins.oe = 4'h0;
						r_nxt.skipop = r_r.cont;
						unique case (r_r.cmd)
						mrw_pkg::MRW_C_QUAD: begin
							r_nxt.st = mrw_pkg::MRW_DUMMY;
							r_nxt.cnt = 6'(`MRW_DUMMY_QUAD);
						end
						mrw_pkg::MRW_C_WORD: begin
							r_nxt.st = mrw_pkg::MRW_DUMMY;
							r_nxt.cnt = 6'(`MRW_DUMMY_WORD);
						end
						default: begin
							r_nxt.st = mrw_pkg::MRW_DATA;
							r_nxt.bitc = 3'd0;
						end
						endcase
					end
				end
			end
			mrw_pkg::MRW_DUMMY: begin
				if (r_r.cnt == 6'd1) begin
					r_nxt.st = mrw_pkg::MRW_DATA;
					r_nxt.bitc = 3'd0;
				end
			end
			mrw_pkg::MRW_DATA: begin
				// Device advances its address each byte
				r_nxt.bitc = r_r.bitc + 3'(step);
				if (r_r.bitc + 3'(step) == 3'd0) begin
					r_nxt.data = r_r.rdbyte;
					r_nxt.valid = 1'b1;
					r_nxt.nbyte = r_r.nbyte + 8'h1;
					if (r_r.nbyte == r_r.len)
						r_nxt.st = mrw_pkg::MRW_GAP;
				end
			end
			mrw_pkg::MRW_GAP: begin
				r_nxt.pins.cs_n = 1'b1;
				r_nxt.pins.oe = 4'h0;
				r_nxt.st = mrw_pkg::MRW_IDLE;
			end
			default: r_nxt.st = mrw_pkg::MRW_IDLE;
			endcase
		end
		// Back-pressure is absent: an unread byte is overwritten
		if (r_nxt.st == mrw_pkg::MRW_IDLE)
			r_nxt.pins.sck = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_r <= '{st: mrw_pkg::MRW_IDLE, cmd: mrw_pkg::MRW_C_DUAL,
				pins: '{cs_n: 1'b1, default: '0},
				wrapb: 8'h10, default: '0};
		end else begin
			r_r <= r_nxt;
		end
	end

	assign prdata = r_r.prdata;
	assign pready = r_r.pready;
	assign pslverr = 1'b0;
	assign flash_cs_n = r_r.pins.cs_n;
	assign flash_sck = r_r.pins.sck;
	assign data_line_out = r_r.pins.dout;
	assign data_line_oe = r_r.pins.oe;
endmodule

//--- verilog/mrw_defines.svh
// Constants for the multi-line read host controller
`ifndef MRW_DEFINES_SVH
`define MRW_DEFINES_SVH
`define MRW_OFS_CTRL     12'h000
`define MRW_OFS_ADDR     12'h004
`define MRW_OFS_DATA     12'h008
`define MRW_OFS_STAT     12'h00C
`define MRW_CTRL_GO      0
`define MRW_CTRL_CONT    1
`define MRW_CTRL_SKIPOP  2
`define MRW_CTRL_CMD_LSB 4
`define MRW_CTRL_LEN_LSB 8
`define MRW_CTRL_WRAP_LSB 16
`define MRW_STAT_BUSY    0
`define MRW_STAT_VALID   1
`define MRW_OP_DUAL      8'hBB
`define MRW_OP_QUAD      8'hEB
`define MRW_OP_WORD      8'hE7
`define MRW_OP_OCTAL     8'hE3
`define MRW_OP_WRAP      8'h77
`define MRW_OP_MODE_RST  8'hFF
`define MRW_MODE_CONT    8'h20
`define MRW_MODE_EXIT    8'hFF
`define MRW_DUMMY_QUAD   4
`define MRW_DUMMY_WORD   2
`define MRW_DIV_HALF     4
`endif

//--- verilog/mrw_pkg.sv
// Types for the multi-line read host controller
package mrw_pkg;
	typedef enum logic [2:0] {
		MRW_IDLE  = 3'b000,
		MRW_OPC   = 3'b001,
		MRW_ADDR  = 3'b011,
		MRW_MODE  = 3'b010,
		MRW_DUMMY = 3'b110,
		MRW_DATA  = 3'b111,
		MRW_GAP   = 3'b101
	} mrw_state_e;
	typedef enum logic [2:0] {
		MRW_C_DUAL  = 3'h0,
		MRW_C_QUAD  = 3'h1,
		MRW_C_WORD  = 3'h2,
		MRW_C_OCTAL = 3'h3,
		MRW_C_WRAP  = 3'h4,
		MRW_C_MRST  = 3'h5
	} mrw_cmd_e;
	typedef struct packed {
		logic       cs_n;
		logic       sck;
		logic [3:0] dout;
		logic [3:0] oe;
	} mrw_pins_s;
	typedef struct packed {
		mrw_state_e st;
		mrw_cmd_e   cmd;
		mrw_pins_s  pins;
		logic [3:0] div;
		logic [5:0] cnt;
		logic [31:0] shreg;
		logic [7:0] len;
		logic [7:0] nbyte;
		logic [7:0] rdbyte;
		logic [2:0] bitc;
		logic       cont;
		logic       skipop;
		logic [7:0] wrapb;
		logic [23:0] addr;
		logic [7:0] data;
		logic       valid;
		logic [31:0] prdata;
		logic       pready;
		logic [1:0] sync_a;
		logic [3:0] din_a;
		logic [3:0] din_b;
	} mrw_reg_s;
endpackage

//--- verification/mrw_host_asserts.sv
// Port assertions for the multi-line read host
`timescale 1ns/1ps
module mrw_host_asserts (
	// APB side
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	// Flash pins
	input wire logic        flash_cs_n,
	input wire logic        flash_sck,
	input wire logic [3:0]  data_line_out,
	input wire logic [3:0]  data_line_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	a_go_opens_frame: assert property (psel && penable && pwrite &&
		paddr == 12'h000 && pwdata[0] |-> ##[1:3] !flash_cs_n)
		else $error("frame did not open");
	a_sck_high_four: assert property
		($rose(flash_sck) |-> flash_sck[*4] ##1 !flash_sck)
		else $error("sck high phase wrong");
	a_sck_low_four: assert property ($fell(flash_sck) |-> (!flash_sck)[*4])
		else $error("sck low phase short");
	a_sck_idle_low: assert property (flash_cs_n |-> !flash_sck)
		else $error("sck high while idle");
	a_out_moves_low: assert property
		(!flash_cs_n && $changed(data_line_out) |-> !flash_sck)
		else $error("line changed with sck high");
	a_oe_moves_low: assert property
		(!flash_cs_n && $changed(data_line_oe) |-> !flash_sck)
		else $error("drive changed with sck high");
	a_oe_idle_off: assert property
		(flash_cs_n && $past(flash_cs_n) |-> data_line_oe == 4'h0)
		else $error("lines driven while idle");
	c_frame: cover property ($fell(flash_cs_n));
	c_quad: cover property (data_line_oe == 4'hF);
	c_dual: cover property (data_line_oe == 4'h3);
endmodule
bind mrw_host mrw_host_asserts u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .flash_cs_n, .flash_sck,
	.data_line_out, .data_line_oe);

//--- verification/mrw_flash_model.sv
// Behavioural flash device for the multi-line read host
`timescale 1ns/1ps
module mrw_flash_model #(
	parameter logic QUAD_EN = 1'b1
) (
	// Pins from the host
	input  wire logic       cs_n,
	input  wire logic       sck,
	input  wire logic [3:0] io,
	// Device drive
	output logic      [3:0] dq,
	output logic      [3:0] dq_oe
);
	logic [7:0]  op, mode, wb, b, lastop = 8'h00;
	logic [7:0]  wrapb = 8'h10;
	logic [23:0] a, ad, sz;
	logic        quad, rd, cont = 1'b0;
	int          k, na, nm, st, j;
	initial dq = 4'h0;
	initial dq_oe = 4'h0;
	always @(negedge cs_n) begin
		k = cont ? 8 : 0;
		op = lastop;
	end
	always @(posedge sck) if (!cs_n) begin
		quad = op != 8'hBB;
		rd = op inside {8'hBB, 8'hEB, 8'hE7, 8'hE3} && (QUAD_EN || !quad);
		na = quad ? 6 : 12;
		nm = quad ? 2 : 4;
		st = 8 + na + nm + (op == 8'hEB ? 4 : op == 8'hE7 ? 2 : 0);
		if (k < 8)
			op = {op[6:0], io[0]};
		else if (op == 8'h77)
			wb = {wb[6:0], io[0]};
		else if (k < 8 + na)
			a = quad ? {a[19:0], io} : {a[21:0], io[1:0]};
		else if (k < 8 + na + nm)
			mode = quad ? {mode[3:0], io} : {mode[5:0], io[1:0]};
		k++;
	end
	// Wrap only for the two quad reads that honour it
	always @(negedge sck) if (!cs_n && rd && k >= st) begin
		j = k - st;
		ad = a + 24'(quad ? j / 2 : j / 4);
		sz = 24'd8 << wrapb[6:5];
		if (!wrapb[4] && (op == 8'hEB || op == 8'hE7))
			ad = (a & ~(sz - 24'd1)) | (ad & (sz - 24'd1));
		b = ad[7:0] ^ 8'h5A;
		dq = quad ? 4'(b >> (j % 2 ? 0 : 4)) : 4'(b >> (6 - 2 * (j % 4)));
		dq_oe = quad ? 4'hF : 4'h3;
	end
	always @(posedge cs_n) begin
		dq_oe = 4'h0;
		if (op == 8'h77 && k >= 40)
			wrapb = {1'b0, wb[6:4], 4'h0};
		if (rd && k >= 8 + na + nm)
			cont = mode[5:4] == 2'b10;
		if (op == 8'hFF)
			cont = 1'b0;
		lastop = op;
	end
endmodule

//--- verification/tb_mrw_host.sv
// Self-checking bench for the multi-line read host
`timescale 1ns/1ps
`include "mrw_defines.svh"
module tb_mrw_host;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, tgl = 1'b0, pready, pslverr, cs_n, sck;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0]  dout, oe, dq, dq_oe, io;
	logic [7:0]  wr = 8'h10, l;
	logic [23:0] a;
	int          num_errors = 0, n_checks = 0, seed = 81658;
	always #5 pclk = ~pclk;
	always @(posedge pclk) tgl <= ~tgl;
	// Released lines toggle so a stale level never reads as data
	assign io = (oe & dout) | (dq_oe & dq) | (~oe & ~dq_oe & {4{tgl}});
	mrw_host u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .flash_cs_n(cs_n),
		.flash_sck(sck), .data_line_out(dout), .data_line_oe(oe),
		.data_line_in(io));
	mrw_flash_model u_flash (.cs_n, .sck, .io, .dq, .dq_oe);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] ad,
		input logic [31:0] d = 32'h0);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [7:0] exp_last(logic [2:0] c);
		logic [23:0] sz, e;
		sz = 24'd8 << wr[6:5];
		e = a + 24'(l);
		if (!wr[4] && (c == 3'd1 || c == 3'd2))
			e = (a & ~(sz - 24'd1)) | (e & (sz - 24'd1));
		return e[7:0] ^ 8'h5A;
	endfunction
	task run(input logic [2:0] c, input logic ct);
		int n;
		apb(1'b1, `MRW_OFS_ADDR, {8'h00, a});
		apb(1'b1, `MRW_OFS_CTRL, {8'h00, wr, l, 1'b0, c, 2'b00, ct, 1'b1});
		n = 0;
		do begin
			apb(1'b0, `MRW_OFS_STAT);
			n++;
		end while (r[0] !== 1'b0 && n < 2000);
		chk({31'h0, r[0]}, 32'h0);
		if (c < 3'd4) begin
			apb(1'b0, `MRW_OFS_DATA);
			chk(r, {24'h0, exp_last(c)});
		end
	endtask
	task complete_run;
		$display("Checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#1000000;
		num_errors++;
		complete_run;
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `MRW_OFS_STAT);
		chk(r, 32'h0);
		apb(1'b0, 12'h010);
		chk(r, 32'h0);
		a = 24'h000013;
		l = 8'h20;
		run(3'd1, 1'b0);
		for (int k = 0; k < 5; k++) begin
			wr = 8'($random(seed));
			wr[6:4] = k < 4 ? {2'(k), 1'b0} : 3'b001;
			run(3'd4, 1'b0);
			wr = wr & 8'h70;
			for (int c = 0; c < 4; c++) begin
				a = 24'($random(seed));
				l = 8'($random(seed)) & 8'h4F;
				if (c == 2) a[0] = 1'b0;
				if (c == 3) a[3:0] = 4'h0;
				run(3'(c), 1'b0);
			end
		end
		a = 24'h0000A7;
		run(3'd1, 1'b1);
		apb(1'b0, `MRW_OFS_CTRL);
		chk({31'h0, r[2]}, 32'h1);
		a = 24'h001235;
		run(3'd1, 1'b0);
		a = 24'h00FF00;
		run(3'd0, 1'b0);
		run(3'd0, 1'b1);
		run(3'd5, 1'b0);
		chk({31'h0, u_flash.cont}, 32'h0);
		a = 24'h000452;
		run(3'd2, 1'b0);
		complete_run;
	end
endmodule
